// ---- pfs_top.v ----
// Forced output stop logic with its PWM timer and register port
`timescale 1ns/1ps
`include "pfs_defines.vh"

module pfs_top (
	input  wire        core_clk_i,   // Core clock, 200 MHz
	input  wire        nrst_i,       // Asynchronous reset, active low
	input  wire        ce_i,         // Clock enable, freezes all state
	input  wire [3:0]  addr_i,       // Register address
	input  wire [15:0] wr_data_i,    // Register write data
	input  wire        wr_i,         // Write strobe
	input  wire        rd_i,         // Read strobe
	output wire [15:0] rd_data_o,    // Read data, cycle after strobe
	input  wire        cmp_zero_i,   // Comparator zero trigger pin
	input  wire        cmp_one_i,    // Comparator one trigger pin
	input  wire        ext_irq_a_i,  // External interrupt a pin
	input  wire        ext_irq_b_i,  // External interrupt b pin
	output wire [1:0]  pwm_o,        // Timer outputs
	output wire [1:0]  pwm_oe_n_o,   // Output enables, low drives
	output wire [1:0]  stop1_o,      // Stop 1 active per output
	output wire [1:0]  stop2_o       // Stop 2 active per output
);

	// Software registers
	reg [15:0] ctl_reg;
	reg [1:0]  gate_reg;
	reg        run_reg;
	reg [15:0] period_reg;
	reg [15:0] duty0_reg;
	reg [15:0] duty1_reg;
	reg [15:0] rd_data_reg;
	reg [15:0] rd_data_next;

	// Timer state
	reg [15:0] cnt_reg;
	reg [15:0] cnt_next;

	// Pin synchronisers and filtered levels
	reg [3:0]  sync1_reg;
	reg [3:0]  sync2_reg;
	reg [3:0]  sync3_reg;
	reg [3:0]  filt_reg;
	reg        trig1_d_reg;
	reg        trig2_d_reg;

	// Stop state per output
	reg [1:0]  stop1_reg;
	reg [1:0]  stop1_next;
	reg [1:0]  pend1_reg;
	reg [1:0]  pend1_next;
	reg [1:0]  stop2_reg;
	reg [1:0]  stop2_next;
	reg [1:0]  arm2_reg;
	reg [1:0]  arm2_next;

	// Output stage
	reg [1:0]  out_reg;
	reg [1:0]  out_next;
	reg [1:0]  oe_n_reg;
	reg [1:0]  oe_n_next;

	wire       wr_ctl;
	wire       wr_gate;
	wire       wr_tmr;
	wire       release_wr;
	wire       boundary;
	wire       trig1;
	wire       trig2;
	wire       trig1_rise;
	wire       trig2_rise;
	wire       trig2_fall;
	wire       rel_ok;
	wire       rel_now;
	wire       rel_late;
	wire [1:0] pwm_norm;

	integer    i;
	integer    j;

	// Address decode of writes
	assign wr_ctl     = wr_i & (addr_i == `PFS_ADDR_CTL);
	assign wr_gate    = wr_i & (addr_i == `PFS_ADDR_GATE);
	assign wr_tmr     = wr_i & (addr_i == `PFS_ADDR_TMR);
	assign release_wr = wr_tmr & wr_data_i[`PFS_RELEASE_BIT];

	// Register writes
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_reg    <= `PFS_CTL_RST;
			gate_reg   <= `PFS_GATE_RST;
			run_reg    <= 1'b0;
			period_reg <= `PFS_PERIOD_RST;
			duty0_reg  <= `PFS_DUTY_RST;
			duty1_reg  <= `PFS_DUTY_RST;
		end else if (ce_i) begin
			if (wr_ctl) begin
				ctl_reg <= wr_data_i & `PFS_CTL_MASK;
			end
			if (wr_gate) begin
				gate_reg <= wr_data_i[1:0];
			end
			if (wr_tmr) begin
				run_reg <= wr_data_i[`PFS_RUN_BIT];
			end
			if (wr_i && addr_i == `PFS_ADDR_PERIOD) begin
				period_reg <= wr_data_i;
			end
			if (wr_i && addr_i == `PFS_ADDR_DUTY0) begin
				duty0_reg <= wr_data_i;
			end
			if (wr_i && addr_i == `PFS_ADDR_DUTY1) begin
				duty1_reg <= wr_data_i;
			end
		end
	end

	// Read multiplexer, unmapped reads return zero
	always @* begin
		rd_data_next = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				`PFS_ADDR_CTL: begin
					rd_data_next = ctl_reg;
				end
				`PFS_ADDR_GATE: begin
					rd_data_next = {14'h0, gate_reg};
				end
				`PFS_ADDR_TMR: begin
					rd_data_next = {8'h00, run_reg, 7'h0};
				end
				`PFS_ADDR_STAT: begin
					rd_data_next = {10'h0, pend1_reg, stop2_reg,
						stop1_reg};
				end
				`PFS_ADDR_CNT: begin
					rd_data_next = cnt_reg;
				end
				`PFS_ADDR_PERIOD: begin
					rd_data_next = period_reg;
				end
				`PFS_ADDR_DUTY0: begin
					rd_data_next = duty0_reg;
				end
				`PFS_ADDR_DUTY1: begin
					rd_data_next = duty1_reg;
				end
				default: begin
					rd_data_next = 16'h0000;
				end
			endcase
		end
	end

	// Read data register, stands one cycle only
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_reg <= 16'h0000;
		end else if (ce_i) begin
			rd_data_reg <= rd_data_next;
		end
	end

	// Counter: halted at all ones, wraps at the period value
	always @* begin
		cnt_next = cnt_reg;
		if (!run_reg) begin
			cnt_next = `PFS_CNT_STOP;
		end else if (cnt_reg == period_reg || cnt_reg == `PFS_CNT_STOP) begin
			cnt_next = 16'h0000;
		end else begin
			cnt_next = cnt_reg + 16'h0001;
		end
	end

	// Period boundary only while running, so a halt defers it
	assign boundary = run_reg & (cnt_reg == period_reg);

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= `PFS_CNT_STOP;
		end else if (ce_i) begin
			cnt_reg <= cnt_next;
		end
	end

	// Three-stage pin synchronisers with agreement filter
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 4'h0;
			filt_reg  <= 4'h0;
		end else if (ce_i) begin
			sync1_reg <= {ext_irq_b_i, ext_irq_a_i, cmp_one_i, cmp_zero_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// Filtered level moves only where stages two and three agree
			filt_reg  <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) |
				(filt_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// Selected trigger levels for each stop function
	assign trig1 = (filt_reg[1] & ctl_reg[`PFS_S1_COMPARATOR_ONE_BIT]) |
		(filt_reg[0] & ctl_reg[`PFS_S1_COMPARATOR_ZERO_BIT]);
	assign trig2 = (filt_reg[3] & ctl_reg[`PFS_S2_EXT1_BIT]) |
		(filt_reg[2] & ctl_reg[`PFS_S2_EXT0_BIT]) |
		(filt_reg[1] & ctl_reg[`PFS_S2_COMPARATOR_ONE_BIT]) |
		(filt_reg[0] & ctl_reg[`PFS_S2_COMPARATOR_ZERO_BIT]);

	// Trigger edges
	assign trig1_rise = trig1 & ~trig1_d_reg;
	assign trig2_rise = trig2 & ~trig2_d_reg;
	assign trig2_fall = ~trig2 & trig2_d_reg;

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			trig1_d_reg <= 1'b0;
			trig2_d_reg <= 1'b0;
		end else if (ce_i) begin
			trig1_d_reg <= trig1;
			trig2_d_reg <= trig2;
		end
	end

	// Release acceptance and its timing by clear code
	assign rel_ok   = release_wr &
		(~ctl_reg[`PFS_S1_CLRL_BIT] | ~trig1);
	assign rel_now  = rel_ok & ~ctl_reg[`PFS_S1_CLRH_BIT];
	assign rel_late = rel_ok & ctl_reg[`PFS_S1_CLRH_BIT];

	// Next stop state per output, a new trigger wins over a clear
	always @* begin
		stop1_next = stop1_reg;
		pend1_next = pend1_reg;
		stop2_next = stop2_reg;
		arm2_next  = arm2_reg;
		for (i = 0; i < 2; i = i + 1) begin
			// Stop 1 set, immediate clear or deferred clear
			stop1_next[i] = (trig1_rise & gate_reg[i]) |
				(stop1_reg[i] & ~rel_now &
				~(pend1_reg[i] & boundary));
			pend1_next[i] = ~(trig1_rise & gate_reg[i]) & stop1_next[i] &
				((pend1_reg[i] & ~boundary) | rel_late);
			// Stop 2 set, armed by start or reverse edge
			stop2_next[i] = (trig2_rise & gate_reg[i]) |
				(stop2_reg[i] & ~(arm2_reg[i] & boundary));
			arm2_next[i]  = ~(trig2_rise & gate_reg[i]) & stop2_next[i] &
				(arm2_reg[i] | ~ctl_reg[`PFS_S2_MODE_BIT] |
				trig2_fall);
		end
	end

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stop1_reg <= 2'h0;
			pend1_reg <= 2'h0;
			stop2_reg <= 2'h0;
			arm2_reg  <= 2'h0;
		end else if (ce_i) begin
			stop1_reg <= stop1_next;
			pend1_reg <= pend1_next;
			stop2_reg <= stop2_next;
			arm2_reg  <= arm2_next;
		end
	end

	// Normal PWM waveform from the counter
	assign pwm_norm[0] = run_reg & (cnt_reg < duty0_reg);
	assign pwm_norm[1] = run_reg & (cnt_reg < duty1_reg);

	// Output selection, stop 1 takes precedence over stop 2
	always @* begin
		out_next  = pwm_norm;
		oe_n_next = 2'h0;
		for (j = 0; j < 2; j = j + 1) begin
			if (stop1_next[j]) begin
				// Hi-Z for codes 00 and 01
				out_next[j]  = ctl_reg[`PFS_OST_HI_BIT] &
					ctl_reg[`PFS_OST_LO_BIT];
				oe_n_next[j] = ~ctl_reg[`PFS_OST_HI_BIT];
			end else if (stop2_next[j]) begin
				out_next[j]  = ctl_reg[`PFS_OST_LO_BIT];
				oe_n_next[j] = 1'b0;
			end else begin
				out_next[j]  = pwm_norm[j];
				oe_n_next[j] = 1'b0;
			end
		end
	end

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_reg  <= 2'h0;
			oe_n_reg <= 2'h0;
		end else if (ce_i) begin
			out_reg  <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data_o  = rd_data_reg;
	assign pwm_o      = out_reg;
	assign pwm_oe_n_o = oe_n_reg;
	assign stop1_o    = stop1_reg;
	assign stop2_o    = stop2_reg;

endmodule

// ---- pfs_defines.vh ----
// Constants for the forced output stop block of the PWM timer
// Summary of operation
// - Stop 2 starts on trigger; clears at period, or period after reverse edge.
// - Stop 1 comparator selects: bit 5 comparator one, bit 4 comparator zero.
// - Stop 1 starts when a selected trigger turns active, any clear code.
// - Codes 00 and 10 accept a release write at any trigger level.
// - Codes 01 and 11 ignore a release write while the trigger is active.
// - Codes 00/01 clear at once; 10/11 clear at the next period boundary.
// - Timer halted before that boundary keeps stop active until run again.
// - Output state field: Hi-Z or level for stop 1, level for stop 2.
// - Per-output trigger gate bits 1 and 0; 0 disables forced stopping.
// - Stop 2 enables: bits 15,14 external interrupts; 13,12 comparators.
// - Run bit low stops counting and loads all ones; high counts.
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH

// Register addresses
`define PFS_ADDR_CTL      4'h0
`define PFS_ADDR_GATE     4'h1
`define PFS_ADDR_TMR      4'h2
`define PFS_ADDR_STAT     4'h3
`define PFS_ADDR_CNT      4'h4
`define PFS_ADDR_PERIOD   4'h5
`define PFS_ADDR_DUTY0    4'h6
`define PFS_ADDR_DUTY1    4'h7

// Control register fields
`define PFS_S2_EXT1_BIT   15
`define PFS_S2_EXT0_BIT   14
`define PFS_S2_COMPARATOR_ONE_BIT   13
`define PFS_S2_COMPARATOR_ZERO_BIT   12
`define PFS_S2_MODE_BIT   8
`define PFS_S1_COMPARATOR_ONE_BIT   5
`define PFS_S1_COMPARATOR_ZERO_BIT   4
`define PFS_S1_CLRH_BIT   3
`define PFS_S1_CLRL_BIT   2
`define PFS_OST_HI_BIT    1
`define PFS_OST_LO_BIT    0
`define PFS_CTL_MASK      16'hF13F

// Timer control register fields
`define PFS_RUN_BIT       7
`define PFS_RELEASE_BIT   0

// Reset values
`define PFS_CTL_RST       16'h0000
`define PFS_GATE_RST      2'h0
`define PFS_PERIOD_RST    16'h00FF
`define PFS_DUTY_RST      16'h0000
`define PFS_CNT_STOP      16'hFFFF

`endif

// ---- pfs_trig_model.sv ----
// Trigger source model: comparators and external interrupt pins
`timescale 1ns/1ps
module pfs_trig_model (
	input  wire logic       core_clk_i, // Clock
	input  wire logic [3:0] lvl_i,      // Requested levels
	output logic      [3:0] trig_o      // irq b, irq a, comparator_one, comparator_zero
);
	// Pins idle low, then follow requests just after an edge
	initial trig_o = 4'h0;
	always @(posedge core_clk_i) trig_o <= lvl_i;
endmodule

// ---- pfs_top_chk.sv ----
// Port assertions for the forced output stop block
`timescale 1ns/1ps
module pfs_top_chk (
	input wire logic        core_clk_i,  // Clock
	input wire logic        nrst_i,      // Reset
	input wire logic        ce_i,        // Enable
	input wire logic [3:0]  addr_i,      // Address
	input wire logic        rd_i,        // Read
	input wire logic [15:0] rd_data_o,   // Read data
	input wire logic        cmp_zero_i,  // Trigger
	input wire logic        cmp_one_i,   // Trigger
	input wire logic        ext_irq_a_i, // Trigger
	input wire logic        ext_irq_b_i, // Trigger
	input wire logic [1:0]  pwm_o,       // Outputs
	input wire logic [1:0]  pwm_oe_n_o,  // Enables
	input wire logic [1:0]  stop1_o,     // Stop 1
	input wire logic [1:0]  stop2_o      // Stop 2
);
	logic [7:0] cmp_hist_reg; // Recent comparator levels
	logic [7:0] any_hist_reg; // Recent trigger levels
	// Trigger history, long enough to cover the input filter
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmp_hist_reg <= 8'h00;
			any_hist_reg <= 8'h00;
		end else begin
			cmp_hist_reg <= {cmp_hist_reg[6:0], cmp_zero_i | cmp_one_i};
			any_hist_reg <= {any_hist_reg[6:0], cmp_zero_i | cmp_one_i
				| ext_irq_a_i | ext_irq_b_i};
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// Read port and stop checks
	a_rd_idle_zero:
		assert property ($past(ce_i) && !$past(rd_i) |->
		rd_data_o == 16'h0000) else $error("read data not idle");
	a_rd_unmapped_zero:
		assert property ($past(rd_i) && $past(addr_i[3]) |->
		rd_data_o == 16'h0000) else $error("unmapped read not zero");
	a_stop1_cause:
		assert property ($rose(stop1_o[0]) || $rose(stop1_o[1])
		|-> cmp_hist_reg != 8'h00) else $error("stop 1 without trigger");
	a_stop2_cause:
		assert property ($rose(stop2_o[0]) || $rose(stop2_o[1])
		|-> any_hist_reg != 8'h00) else $error("stop 2 without trigger");
	a_hiz_only_stop1:
		assert property ((pwm_oe_n_o & ~stop1_o) == 2'b00)
		else $error("Hi-Z without stop 1");
	a_hiz_low_level:
		assert property ((pwm_oe_n_o & pwm_o) == 2'b00)
		else $error("Hi-Z output not low");
	a_stop_level_held:
		assert property ((stop1_o[0] | stop2_o[0]) && $stable(stop1_o)
		&& $stable(stop2_o) && $past(stop1_o[0] | stop2_o[0])
		|-> $stable(pwm_o[0])) else $error("stopped output moved");
	a_reset_idle:
		assert property ($rose(nrst_i) |-> stop1_o == 2'b00
		&& stop2_o == 2'b00) else $error("stop active after reset");
	c_stop1: cover property ($rose(stop1_o[0]));
	c_stop2: cover property ($rose(stop2_o[1]));
	c_hiz: cover property (pwm_oe_n_o[0]);
endmodule
bind pfs_top pfs_top_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.ce_i(ce_i), .addr_i(addr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
	.cmp_zero_i(cmp_zero_i), .cmp_one_i(cmp_one_i),
	.ext_irq_a_i(ext_irq_a_i), .ext_irq_b_i(ext_irq_b_i), .pwm_o(pwm_o),
	.pwm_oe_n_o(pwm_oe_n_o), .stop1_o(stop1_o), .stop2_o(stop2_o));

// ---- pfs_top_tb.sv ----
// Self-checking bench for the forced output stop block
`timescale 1ns/1ps
`include "pfs_defines.vh"
module pfs_top_tb;
	typedef struct packed {logic w; logic [3:0] a; logic [15:0] d;} pfs_row_t;
	logic        core_clk_i = 1'b0;
	logic        nrst_i     = 1'b0;
	logic [3:0]  addr_i     = 4'h0;
	logic [15:0] wr_data_i  = 16'h0000;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic        ce_i       = 1'b1;
	logic [1:0]  frz;
	logic [3:0]  lvl        = 4'h0;
	logic [3:0]  trig;
	logic [15:0] rd_data_o;
	logic [1:0]  pwm_o, pwm_oe_n_o, stop1_o, stop2_o;
	int          num_errors = 0;
	int          checks     = 0;
	int          i;
	int          hi0;
	int          hi1;
	// Register rows: reads carry expected data, writes carry data
	pfs_row_t rows [13] = '{
		'{1'b0, `PFS_ADDR_CTL, `PFS_CTL_RST},
		'{1'b0, `PFS_ADDR_GATE, 16'h0000},
		'{1'b0, `PFS_ADDR_PERIOD, `PFS_PERIOD_RST},
		'{1'b0, `PFS_ADDR_CNT, `PFS_CNT_STOP},
		'{1'b1, `PFS_ADDR_CTL, 16'hFFFF},
		'{1'b0, `PFS_ADDR_CTL, `PFS_CTL_MASK},
		'{1'b1, `PFS_ADDR_GATE, 16'hFFFF},
		'{1'b0, `PFS_ADDR_GATE, 16'h0003},
		'{1'b1, 4'hA, 16'hFFFF},
		'{1'b0, 4'hA, 16'h0000},
		'{1'b1, `PFS_ADDR_PERIOD, 16'h000F},
		'{1'b0, `PFS_ADDR_PERIOD, 16'h000F},
		'{1'b1, `PFS_ADDR_DUTY0, 16'h0008}
	};
	pfs_trig_model u_trig (.core_clk_i(core_clk_i), .lvl_i(lvl),
		.trig_o(trig));
	pfs_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .cmp_zero_i(trig[0]), .cmp_one_i(trig[1]),
		.ext_irq_a_i(trig[2]), .ext_irq_b_i(trig[3]), .pwm_o(pwm_o),
		.pwm_oe_n_o(pwm_oe_n_o), .stop1_o(stop1_o), .stop2_o(stop2_o));
	always #2.5 core_clk_i = ~core_clk_i;
	// Compare and count; tasks end one step after an edge
	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("Checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk("read data", e, rd_data_o);
		@(posedge core_clk_i);
		#1 chk("read idle", 16'h0000, rd_data_o);
	endtask
	task automatic trg(input logic [3:0] v);
		@(posedge core_clk_i);
		lvl <= v;
		#1;
	endtask
	task automatic stay(input logic [3:0] e, input int n);
		repeat (n) @(posedge core_clk_i);
		#1 chk("stop held", {12'h000, e}, {12'h000, stop2_o, stop1_o});
	endtask
	task automatic waitst(input logic [3:0] e, input int lim);
		int k;
		k = 0;
		while (k < lim && {stop2_o, stop1_o} !== e) begin
			@(posedge core_clk_i);
			#1 k++;
		end
		chk("stop reach", {12'h000, e}, {12'h000, stop2_o, stop1_o});
		if ({stop2_o, stop1_o} !== e)
			end_of_test();
	endtask
	initial begin
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].w)
				wr(rows[k].a, rows[k].d);
			else
				rd(rows[k].a, rows[k].d);
		end
		// Stop 1 from comparator one only, Hi-Z, output 0 gated in
		wr(`PFS_ADDR_TMR, 16'h0080);
		wr(`PFS_ADDR_GATE, 16'h0001);
		wr(`PFS_ADDR_CTL, 16'h0020);
		trg(4'h1);
		stay(4'h0, 12);
		trg(4'h2);
		waitst(4'h1, 12);
		chk("hiz", 16'h0001, {14'h0, pwm_oe_n_o});
		wr(`PFS_ADDR_TMR, 16'h0081);
		stay(4'h0, 1);
		trg(4'h0);
		stay(4'h0, 4);
		// Clear code 01: release refused while trigger active
		wr(`PFS_ADDR_CTL, 16'h0024);
		trg(4'h2);
		waitst(4'h1, 12);
		wr(`PFS_ADDR_TMR, 16'h0081);
		stay(4'h1, 20);
		trg(4'h0);
		stay(4'h1, 8);
		wr(`PFS_ADDR_TMR, 16'h0081);
		stay(4'h0, 1);
		// Clear code 10, low level: release waits for period
		wr(`PFS_ADDR_CTL, 16'h002A);
		trg(4'h2);
		waitst(4'h1, 12);
		chk("low out", 16'h0000, {12'h0, pwm_oe_n_o, pwm_o});
		wr(`PFS_ADDR_TMR, 16'h0081);
		chk("deferred", 16'h0001, {14'h0, stop1_o});
		waitst(4'h0, 20);
		trg(4'h0);
		stay(4'h0, 4);
		// High level, release while halted, then restart
		wr(`PFS_ADDR_CTL, 16'h002B);
		trg(4'h2);
		waitst(4'h1, 12);
		chk("high out", 16'h0001, {14'h0, pwm_o});
		trg(4'h0);
		wr(`PFS_ADDR_TMR, 16'h0000);
		wr(`PFS_ADDR_TMR, 16'h0001);
		stay(4'h1, 40);
		rd(`PFS_ADDR_CNT, `PFS_CNT_STOP);
		wr(`PFS_ADDR_TMR, 16'h0080);
		waitst(4'h0, 25);
		// Normal waveform: duty 8 of a 16-count period, output 1 idle
		hi0 = 0;
		hi1 = 0;
		repeat (16) begin
			@(posedge core_clk_i);
			#1 hi0 += pwm_o[0];
			hi1 += pwm_o[1];
		end
		chk("pwm0 duty", 16'h0008, hi0[15:0]);
		chk("pwm1 duty", 16'h0000, hi1[15:0]);
		// Clock enable low freezes the running outputs
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		#1 frz = pwm_o;
		repeat (20) begin
			@(posedge core_clk_i);
			#1 chk("frozen", {14'h0, frz}, {14'h0, pwm_o});
		end
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		// Stop 2 mode 1 from each source, high level
		wr(`PFS_ADDR_GATE, 16'h0003);
		for (i = 0; i < 4; i++) begin
			wr(`PFS_ADDR_CTL, (16'h1000 << i) | 16'h0101);
			trg(4'h1 << i);
			waitst(4'hC, 12);
			chk("stop2 out", 16'h0003, {14'h0, pwm_o});
			stay(4'hC, 40);
			trg(4'h0);
			waitst(4'h0, 30);
		end
		// Stop 2 mode 0 clears at the period with trigger held
		wr(`PFS_ADDR_CTL, 16'h4000);
		trg(4'h4);
		waitst(4'hC, 12);
		chk("stop2 low", 16'h0000, {14'h0, pwm_o});
		waitst(4'h0, 20);
		trg(4'h0);
		stay(4'h0, 6);
		// Reset in mid-run with stop 2 active clears every stop
		trg(4'h4);
		waitst(4'hC, 12);
		trg(4'h0);
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		#1 chk("reset stop", 16'h0000, {12'h0, stop2_o, stop1_o});
		chk("reset out", 16'h0000, {12'h0, pwm_oe_n_o, pwm_o});
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rd(`PFS_ADDR_CTL, `PFS_CTL_RST);
		rd(`PFS_ADDR_CNT, `PFS_CNT_STOP);
		end_of_test();
	end
endmodule
